// [core/oltf_lut_bank.sv]
`include "oltf_map.svh"

// one partial-product table with its own address multiplexer
module oltf_lut_bank #(
  parameter int DEPTH = `OLTF_LUT_DEPTH,
  parameter int AW    = `OLTF_LUT_AW,
  parameter int DW    = `OLTF_PP_W
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 read_mode,
  input  wire logic [AW-1:0]        rd_addr,
  input  wire oltf_pkg::oltf_wr_type wr,
  output logic      [DW-1:0]        rd_data
);

  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] mem_d [DEPTH];
  logic [AW-1:0] addr;

  // read mode takes the sample piece, else the write address
  assign addr    = read_mode ? rd_addr : wr.addr;
  assign rd_data = mem_q[addr];

  // writes land only while this table is not being read
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (!read_mode && wr.we) begin
      mem_d[addr] = wr.data;
    end
  end

  // one word of flip-flops per table entry
  for (genvar g = 0; g < DEPTH; g++) begin : g_word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[g] <= '0;
      end else begin
        mem_q[g] <= mem_d[g];
      end
    end
  end

endmodule

// [core/oltf_map.svh]
`ifndef OLTF_MAP_SVH
`define OLTF_MAP_SVH

// sample and coefficient widths
`define OLTF_SAMPLE_W    12
`define OLTF_COEF_W      12
// one piece: three data bits plus one control bit
`define OLTF_OCTET_W     3
`define OLTF_PIECE_W     4
`define OLTF_PIECES      4
// lookup table shape
`define OLTF_LUT_DEPTH   16
`define OLTF_LUT_AW      4
`define OLTF_PP_W        15
`define OLTF_LUT_LAST    4'hf
// reset values
`define OLTF_PP_RST      15'h0000
`define OLTF_PIECE_RST   4'h0
`define OLTF_COEF_RST    12'h000

`endif

// [core/oltf_pkg.sv]
package oltf_pkg;

`include "oltf_map.svh"

  // one framed piece of a sample
  typedef struct packed {
    logic                       ctrl;
    logic [`OLTF_OCTET_W-1:0]   octet;
  } oltf_piece_type;

  // write request towards one table
  typedef struct packed {
    logic                       we;
    logic [`OLTF_LUT_AW-1:0]    addr;
    logic [`OLTF_PP_W-1:0]      data;
  } oltf_wr_type;

  // table refill sequence
  typedef enum logic [1:0] {
    FILL_IDLE,
    FILL_RUN,
    FILL_SWAP
  } oltf_fill_type;

endpackage

// [core/oltf_tap_front.sv]
// Contract
// - 12-bit samples times 12-bit coefficient, full precision
// - sample cut into four octets, each with control
// - four-stage, 4-bit skew register holds one sample
// - one piece shifted out per clock, both ways
// - new product per piece, every clock; sample passed onward
// - skew register kept even in the first tap
// - 16-word, 15-bit tables addressed by the piece
// - two tables: one read, other rewritten meanwhile
// - bank select drives one address mux inverted
// - words 0-7 unsigned, 8-15 signed multiples, 15-bit
`include "oltf_map.svh"

module oltf_tap_front #(
  parameter int COEF_W  = `OLTF_COEF_W,
  parameter int PP_W    = `OLTF_PP_W,
  parameter int PIECES  = `OLTF_PIECES
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire oltf_pkg::oltf_piece_type  piece_in,
  input  wire logic                      coef_load,
  input  wire logic [COEF_W-1:0]         coef_in,
  output oltf_pkg::oltf_piece_type       piece_out,
  output logic      [PP_W-1:0]           pp_out,
  output logic                           pp_top,
  output logic                           bank_sel,
  output logic                           fill_busy
);

  // reset release
  // rst_n is the released copy that every flop except rst_sync_q uses
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // skew register
  oltf_pkg::oltf_piece_type tsb_q [PIECES];
  oltf_pkg::oltf_piece_type tsb_d [PIECES];
  oltf_pkg::oltf_piece_type tap_piece;

  // tables
  // bank_rd holds both table outputs, only one is live
  logic [PP_W-1:0]        bank_rd [2];
  logic [1:0]             bank_read_mode;
  oltf_pkg::oltf_wr_type  wr;

  // refill sequence
  // idx_q walks the idle table word by word
  oltf_pkg::oltf_fill_type  fill_q;
  oltf_pkg::oltf_fill_type  fill_d;
  logic [`OLTF_LUT_AW-1:0]  idx_q;
  logic [`OLTF_LUT_AW-1:0]  idx_d;
  logic [COEF_W-1:0]        coef_q;
  logic [COEF_W-1:0]        coef_d;
  logic                     bank_sel_q;
  logic                     bank_sel_d;
  logic                     fill_busy_q;
  logic                     fill_busy_d;

  // product output
  logic [PP_W-1:0] pp_q;
  logic [PP_W-1:0] pp_d;
  logic            pp_top_q;
  logic            pp_top_d;

  // table word: index times coefficient; upper half signed octet
  function automatic logic [PP_W-1:0] lut_word(
    input logic [`OLTF_LUT_AW-1:0] idx,
    input logic [COEF_W-1:0]       c
  );
    logic signed [`OLTF_LUT_AW-1:0] m;
    logic signed [PP_W:0]           p;
    if (idx[`OLTF_LUT_AW-1]) begin
      m = $signed({idx[`OLTF_OCTET_W-1], idx[`OLTF_OCTET_W-1:0]});
    end else begin
      m = $signed({1'b0, idx[`OLTF_OCTET_W-1:0]});
    end
    p = m * $signed(c);
    lut_word = p[PP_W-1:0];
  endfunction

  // two-flop release of the asynchronous reset
  // entry is immediate; only the release waits two edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // skew register: pieces move one stage per clock, every tap
  // kept in tap zero as well so every tap is the same
  always_comb begin
    tsb_d[0] = piece_in;
    for (int i = 1; i < PIECES; i++) begin
      tsb_d[i] = tsb_q[i-1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PIECES; i++) begin
        tsb_q[i] <= `OLTF_PIECE_RST;
      end
    end else begin
      for (int i = 0; i < PIECES; i++) begin
        tsb_q[i] <= tsb_d[i];
      end
    end
  end

  // the last stage feeds both the lookup and the next tap
  assign tap_piece = tsb_q[PIECES-1];

  // refill: write all sixteen words, then flip at a sample edge
  // a load arriving mid-refill is dropped without notice
  always_comb begin
    fill_d      = fill_q;
    idx_d       = idx_q;
    coef_d      = coef_q;
    bank_sel_d  = bank_sel_q;
    wr.we       = 1'b0;
    wr.addr     = idx_q;
    wr.data     = lut_word(idx_q, coef_q);
    unique case (fill_q)
      oltf_pkg::FILL_IDLE: begin
        if (coef_load) begin
          coef_d = coef_in;
          idx_d  = '0;
          fill_d = oltf_pkg::FILL_RUN;
        end
      end
      oltf_pkg::FILL_RUN: begin
        wr.we = 1'b1;
        idx_d = idx_q + 1'b1;
        if (idx_q == `OLTF_LUT_LAST) begin
          fill_d = oltf_pkg::FILL_SWAP;
        end
      end
      oltf_pkg::FILL_SWAP: begin
        // top octet now read: next piece starts a new sample
        if (tap_piece.ctrl) begin
          bank_sel_d = ~bank_sel_q;
          fill_d     = oltf_pkg::FILL_IDLE;
        end
      end
      // unused encoding falls back to idle
      default: begin
        fill_d = oltf_pkg::FILL_IDLE;
      end
    endcase
    fill_busy_d = (fill_d != oltf_pkg::FILL_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_q      <= oltf_pkg::FILL_IDLE;
      idx_q       <= '0;
      coef_q      <= `OLTF_COEF_RST;
      bank_sel_q  <= 1'b0;
      fill_busy_q <= 1'b0;
    end else begin
      fill_q      <= fill_d;
      idx_q       <= idx_d;
      coef_q      <= coef_d;
      bank_sel_q  <= bank_sel_d;
      fill_busy_q <= fill_busy_d;
    end
  end

  // table 0 reads on bank select low, table 1 on high
  // the idle table only ever sees write addresses
  for (genvar b = 0; b < 2; b++) begin : g_bank
    assign bank_read_mode[b] = (b == 0) ? ~bank_sel_q : bank_sel_q;
    oltf_lut_bank #(
      .DEPTH (`OLTF_LUT_DEPTH),
      .AW    (`OLTF_LUT_AW),
      .DW    (PP_W)
    ) u_bank (
      .clk       (clk),
      .rst_n     (rst_n),
      .read_mode (bank_read_mode[b]),
      .rd_addr   (tap_piece),
      .wr        (wr),
      .rd_data   (bank_rd[b])
    );
  end

  // product register from the readable table, tagged with top octet
  // at a flip the top octet still reads the old table
  always_comb begin
    pp_d     = bank_sel_q ? bank_rd[1] : bank_rd[0];
    pp_top_d = tap_piece.ctrl;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pp_q     <= `OLTF_PP_RST;
      pp_top_q <= 1'b0;
    end else begin
      pp_q     <= pp_d;
      pp_top_q <= pp_top_d;
    end
  end

  // outputs straight from flip-flops
  // piece_out is the last skew stage itself
  assign piece_out = tap_piece;
  assign pp_out    = pp_q;
  assign pp_top    = pp_top_q;
  assign bank_sel  = bank_sel_q;
  assign fill_busy = fill_busy_q;

endmodule

// [sim/oltf_framer.sv]
// same-clock framer: octets low to high, control on the top one
module oltf_framer (
  input  wire logic                clk,
  input  wire logic                run,
  output oltf_pkg::oltf_piece_type piece
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] sample_q = 12'h5a3;
  logic [1:0]  idx_q = 2'h0;
  initial piece = '0;
  // one piece per clock, new sample every fourth
  always @(negedge clk) begin
    if (!run) begin
      piece <= '0;
      idx_q <= 2'h0;
    end else begin
      piece <= {idx_q == 2'h3, sample_q[3*idx_q +: 3]};
      idx_q <= idx_q + 2'h1;
      if (idx_q == 2'h3) sample_q <= sample_q + 12'h2d7;
    end
  end
endmodule

// [sim/oltf_tap_asserts.sv]
module oltf_tap_asserts (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire oltf_pkg::oltf_piece_type piece_in,
  input wire logic                    coef_load,
  input wire logic [11:0]             coef_in,
  input wire oltf_pkg::oltf_piece_type piece_out,
  input wire logic [14:0]             pp_out,
  input wire logic                    pp_top,
  input wire logic                    bank_sel,
  input wire logic                    fill_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // stream, tables and refill timing
  stream_delay_a: assert property (
    piece_out == $past(piece_in, 4)) else $error("piece delay wrong");
  top_flag_a: assert property (
    pp_top == $past(piece_out.ctrl)) else $error("pp_top wrong");
  zero_word_a: assert property (
    piece_out.octet == 3'h0 |=> pp_out == 15'h0) else $error("word 0 set");
  load_take_a: assert property (
    coef_load && !fill_busy |=> fill_busy) else $error("load lost");
  fill_span_a: assert property (
    $rose(fill_busy) |-> ##16 fill_busy) else $error("refill too short");
  fill_bound_a: assert property (
    $rose(fill_busy) |-> ##[16:40] !fill_busy) else $error("refill hung");
  flip_when_a: assert property (
    $changed(bank_sel) |-> $past(fill_busy && piece_out.ctrl))
    else $error("bank flip off boundary");
  busy_fall_a: assert property (
    $fell(fill_busy) |-> $changed(bank_sel)) else $error("no flip");
endmodule

bind oltf_tap_front oltf_tap_asserts chk (.clk(clk), .reset_n(reset_n),
  .piece_in(piece_in), .coef_load(coef_load), .coef_in(coef_in),
  .piece_out(piece_out), .pp_out(pp_out), .pp_top(pp_top),
  .bank_sel(bank_sel), .fill_busy(fill_busy));

// [sim/oltf_tap_front_bench.sv]
module oltf_tap_front_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk, reset_n, coef_load, run, bank_x;
  logic [11:0]              coef_in, coef_x;
  logic [14:0]              pp_out;
  logic                     pp_top, bank_sel, fill_busy;
  oltf_pkg::oltf_piece_type piece_in, piece_out;
  oltf_pkg::oltf_piece_type hist [6];
  int                       errors = 0;
  int                       n_checks = 0;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  oltf_framer frm (.clk(clk), .run(run), .piece(piece_in));
  oltf_tap_front uut (.clk(clk), .reset_n(reset_n), .piece_in(piece_in),
    .coef_load(coef_load), .coef_in(coef_in), .piece_out(piece_out),
    .pp_out(pp_out), .pp_top(pp_top), .bank_sel(bank_sel),
    .fill_busy(fill_busy));
  // pieces taken by the tap, newest first
  always @(posedge clk) begin
    for (int i = 5; i > 0; i--) hist[i] <= hist[i-1];
    hist[0] <= piece_in;
  end
  // expected table word for one piece
  function logic [14:0] lut_x(oltf_pkg::oltf_piece_type p, logic [11:0] c);
    int s;
    s = p.ctrl ? int'($signed(p.octet)) : int'(p.octet);
    return 15'(s * int'($signed(c)));
  endfunction
  task cmp(string name, logic [14:0] x, logic [14:0] g);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", name, x, g);
    end
  endtask
  task complete_run;
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // eight products against the coefficient in use
  task check_stream;
    repeat (8) begin
      @(negedge clk);
      cmp("pp_out", lut_x(hist[4], coef_x), pp_out);
      cmp("pp_top", 15'(hist[4].ctrl), 15'(pp_top));
      cmp("piece_out", 15'(hist[3]), 15'(piece_out));
    end
  endtask
  // refill while streaming, a second load refused meanwhile
  task load_coef(logic [11:0] c, logic [11:0] ign);
    int n;
    coef_load = 1'b1;
    coef_in = c;
    @(negedge clk);
    cmp("fill_busy", 15'h1, 15'(fill_busy));
    coef_in = ign;
    @(negedge clk);
    coef_load = 1'b0;
    check_stream();
    n = 0;
    while (fill_busy !== 1'b0) begin
      if (n++ == 40) begin
        errors++;
        complete_run();
      end
      @(negedge clk);
    end
    coef_x = c;
    bank_x = ~bank_x;
    cmp("bank_sel", 15'(bank_x), 15'(bank_sel));
    @(negedge clk);
    check_stream();
  endtask
  initial begin
    reset_n = 1'b0;
    coef_load = 1'b0;
    coef_in = 12'h000;
    run = 1'b0;
    coef_x = 12'h000;
    bank_x = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    cmp("bank_sel", 15'h0, 15'(bank_sel));
    repeat (2) @(posedge clk);
    run = 1'b1;
    repeat (8) @(negedge clk);
    check_stream();
    load_coef(12'h7ff, 12'h123);
    load_coef(12'h801, 12'h3c5);
    load_coef(12'h5a6, 12'hfff);
    complete_run();
  end
endmodule
